// ---- pkg/adc_convert_regs.svh ----
// timing counts and result layout for the converter control block
`ifndef ADC_CONVERT_REGS_SVH
`define ADC_CONVERT_REGS_SVH

`define CORE_CLK_PERIOD_NS  25
`define RESULT_BITS         8
`define RESULT_MSB_POS      7
`define RESULT_RESET        8'h00
`define TRIAL_FIRST         8'h80

// acquisition and per-bit step; both are least times, rounded up
`define ACQ_TIME_NS         2000
`define ACQ_CYCLES          ((`ACQ_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define BIT_STEP_NS         500
`define BIT_STEP_CYCLES     ((`BIT_STEP_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

// longest conversion, rounded down
`define CONV_TIME_NS        7500
`define CONV_LIMIT_CYCLES   (`CONV_TIME_NS / `CORE_CLK_PERIOD_NS)

// release delay after the eighth rising shift edge, counted after sync latency
`define HIZ_DELAY_NS        250
`define HIZ_DELAY_CYCLES    ((`HIZ_DELAY_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`define SHIFT_LAST_RISE     4'h7

`endif

// ---- pkg/adc_convert_pkg.sv ----
// types shared by the converter control block
`include "adc_convert_regs.svh"

package adc_convert_pkg;

	typedef enum logic [1:0] {
		ST_SHUTDOWN,
		ST_ACQUIRE,
		ST_CONVERT,
		ST_STORE
	} conv_state_e;

	typedef struct packed {
		logic                      channel;
		logic [`RESULT_BITS-1:0]   code;
	} result_s;

endpackage : adc_convert_pkg

// ---- src/adc_convert_and_serial_readout.sv ----
// converter sequencing, result buffer and serial read-out
`timescale 1ns/100ps
`include "adc_convert_regs.svh"

module result_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;

	wire do_push = in_valid_i && in_ready_o;
	wire do_pop  = out_valid_o && out_ready_i;
	wire [PW-1:0] next_wr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
	wire [PW-1:0] next_rd = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);

	assign in_ready_o  = (count != CW'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge core_clk_i)
	begin
		if (do_push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push)
				wr_ptr <= next_wr;
			if (do_pop)
				rd_ptr <= next_rd;
			if (do_push && !do_pop)
				count <= count + CW'(1);
			else if (do_pop && !do_push)
				count <= count - CW'(1);
		end
	end
endmodule : result_fifo

module adc_convert_and_serial_readout #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        conversion_trigger_i,
	input  wire logic        shift_clk_i,
	input  wire logic        comparator_i,
	output logic             data_out_o,
	output logic             data_out_oe_n_o,
	output logic             analog_power_up_o,
	output logic             sample_track_o,
	output logic             channel_select_o,
	output logic [7:0]       dac_code_o
);
	import adc_convert_pkg::*;

	localparam int RW = $bits(result_s);

	conv_state_e state;
	logic [2:0]  trig_sync;
	logic [2:0]  sclk_sync;
	logic [1:0]  cmp_sync;
	logic [8:0]  timer;
	logic [2:0]  bit_idx;
	logic [7:0]  trial;
	logic [7:0]  shift_reg;
	logic        reading;
	logic        armed;
	logic [3:0]  rise_cnt;
	logic        hiz_wait;
	logic [3:0]  hiz_cnt;
	logic        readout_done;
	logic [8:0]  conv_cycles;

	wire trig_fall  = trig_sync[2] && !trig_sync[1];
	wire sclk_rise  = !sclk_sync[2] && sclk_sync[1];
	wire sclk_fall  = sclk_sync[2] && !sclk_sync[1];
	wire converting = (state != ST_SHUTDOWN);
	wire abort      = trig_fall && converting;
	wire step_end   = (timer == 9'h001);
	wire cmp_below  = cmp_sync[1];
	wire hiz_fire   = hiz_wait && (hiz_cnt == 4'h1);
	wire rise_last  = reading && sclk_rise && (rise_cnt == `SHIFT_LAST_RISE);
	wire shift_now  = reading && sclk_fall && armed && !hiz_wait;

	result_s push_word;
	result_s pop_word;
	logic    fifo_in_ready;
	logic    fifo_out_valid;
	logic [RW-1:0] pop_bits;
	wire     fifo_push = (state == ST_STORE);
	wire     fifo_drain = (state == ST_SHUTDOWN);
	wire     pop = fifo_out_valid && fifo_drain;

	assign push_word.channel = channel_select_o;
	assign push_word.code    = trial;
	assign pop_word          = result_s'(pop_bits);

	// pin inputs: first stage only feeds the second
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i) begin
			trig_sync <= 3'h0;
			sclk_sync <= 3'h0;
			cmp_sync  <= 2'h0;
		end else begin
			trig_sync <= {trig_sync[1:0], conversion_trigger_i};
			sclk_sync <= {sclk_sync[1:0], shift_clk_i};
			cmp_sync  <= {cmp_sync[0], comparator_i};
		end
	end

	// holding the result word when the buffer is full stalls the sequencer
	result_fifo #(
		.WIDTH (RW),
		.DEPTH (FIFO_DEPTH)
	) u_result_fifo (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_word),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_drain),
		.out_data_o  (pop_bits)
	);

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i) begin
			state             <= ST_SHUTDOWN;
			timer             <= 9'h000;
			bit_idx           <= 3'h0;
			trial             <= `RESULT_RESET;
			channel_select_o  <= 1'b0;
			analog_power_up_o <= 1'b0;
			sample_track_o    <= 1'b0;
		end else if (abort) begin
			state             <= ST_ACQUIRE;
			channel_select_o  <= 1'b1;
			timer             <= 9'(`ACQ_CYCLES);
			trial             <= `RESULT_RESET;
			analog_power_up_o <= 1'b1;
			sample_track_o    <= 1'b1;
		end else begin
			case (state)
			ST_SHUTDOWN:
				if (trig_fall)
				begin
					state             <= ST_ACQUIRE;
					channel_select_o  <= !readout_done;
					timer             <= 9'(`ACQ_CYCLES);
					analog_power_up_o <= 1'b1;
					sample_track_o    <= 1'b1;
				end
			ST_ACQUIRE:
				if (step_end)
				begin
					state          <= ST_CONVERT;
					sample_track_o <= 1'b0;
					bit_idx        <= 3'(`RESULT_MSB_POS);
					trial          <= `TRIAL_FIRST;
					timer          <= 9'(`BIT_STEP_CYCLES);
				end else
					timer <= timer - 9'h001;
			ST_CONVERT:
				if (step_end)
				begin
					// binary-weighted trial, straight binary code
					if (cmp_below)
						trial[bit_idx] <= 1'b0;
					if (bit_idx == 3'h0) begin
						state             <= ST_STORE;
						analog_power_up_o <= 1'b0;
					end else begin
						bit_idx                 <= bit_idx - 3'h1;
						trial[bit_idx - 3'h1]   <= 1'b1;
						timer                   <= 9'(`BIT_STEP_CYCLES);
					end
				end else
					timer <= timer - 9'h001;
			ST_STORE:
				if (fifo_in_ready)
					state <= ST_SHUTDOWN;
			default:
				state <= ST_SHUTDOWN;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			dac_code_o <= `RESULT_RESET;
		else
			dac_code_o <= trial;
	end

	// read-out side; edges only count while a result is being presented
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i) begin
			data_out_o      <= 1'b0;
			data_out_oe_n_o <= 1'b1;
			shift_reg       <= `RESULT_RESET;
			reading         <= 1'b0;
			armed           <= 1'b0;
			rise_cnt        <= 4'h0;
			hiz_wait        <= 1'b0;
			hiz_cnt         <= 4'h0;
			readout_done    <= 1'b1;
		end else if (trig_fall) begin
			data_out_o      <= 1'b0;
			data_out_oe_n_o <= 1'b0;
			reading         <= 1'b0;
			armed           <= 1'b0;
			rise_cnt        <= 4'h0;
			hiz_wait        <= 1'b0;
			readout_done    <= hiz_fire;
		end else if (pop) begin
			data_out_o      <= pop_word.code[`RESULT_MSB_POS];
			shift_reg       <= {pop_word.code[6:0], 1'b0};
			data_out_oe_n_o <= 1'b0;
			reading         <= 1'b1;
			armed           <= 1'b0;
			rise_cnt        <= 4'h0;
		end else begin
			// a fall before any rise is the idle-high lead-in, not a shift
			if (reading && sclk_rise) begin
				armed    <= 1'b1;
				rise_cnt <= rise_cnt + 4'h1;
			end
			if (rise_last) begin
				hiz_wait <= 1'b1;
				hiz_cnt  <= 4'(`HIZ_DELAY_CYCLES);
			end else if (hiz_fire) begin
				hiz_wait        <= 1'b0;
				data_out_oe_n_o <= 1'b1;
				reading         <= 1'b0;
				readout_done    <= 1'b1;
			end else if (hiz_wait)
				hiz_cnt <= hiz_cnt - 4'h1;
			if (shift_now) begin
				data_out_o <= shift_reg[7];
				shift_reg  <= {shift_reg[6:0], 1'b0};
			end
		end
	end

	// cycles since the latest start or abort, for the conversion bound
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			conv_cycles <= 9'h000;
		else if (trig_fall || !converting)
			conv_cycles <= 9'h000;
		else
			conv_cycles <= conv_cycles + 9'h001;
	end
	localparam int HIZ_LO = 1;
	localparam int HIZ_HI = 4;
	localparam int CONV_LIMIT = `CONV_LIMIT_CYCLES;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence seq_start_seen;
		trig_fall && !converting;
	endsequence
	sequence seq_eighth_rise;
		rise_last && !trig_fall && !pop;
	endsequence
	sequence seq_release;
		!data_out_oe_n_o [*8] ##[HIZ_LO:HIZ_HI] data_out_oe_n_o;
	endsequence

	trig_start_a: assert property (seq_start_seen |=>
		(state == ST_ACQUIRE) && analog_power_up_o)
		else $error("trigger fall did not start acquisition");
	out_low_a: assert property (converting |-> !data_out_o && !data_out_oe_n_o)
		else $error("serial output not driven low during conversion");
	msb_first_a: assert property (pop && !trig_fall |=> data_out_o == $past(pop_bits[7]))
		else $error("completion did not present the MSB");
	conv_bound_a: assert property (conv_cycles <= 9'(CONV_LIMIT))
		else $error("conversion longer than allowed");
	shift_ignored_a: assert property (converting && sclk_fall |=> !data_out_o)
		else $error("shift clock acted during conversion");
	abort_second_a: assert property (abort |=> channel_select_o && (state == ST_ACQUIRE))
		else $error("abort did not select second input");
	// a new trigger inside the release window legally keeps the pin driven
	release_time_a: assert property (disable iff (!reset_n_i || trig_fall)
		seq_eighth_rise |-> ##1 seq_release)
		else $error("output release outside timing window");
	auto_off_a: assert property ($past(converting) && !converting |-> !analog_power_up_o)
		else $error("analog section left powered after conversion");
	next_bit_a: assert property (shift_now && !trig_fall && !pop |=>
		data_out_o == $past(shift_reg[7]))
		else $error("shift did not present next lower bit");
endmodule : adc_convert_and_serial_readout

// ---- verif/host_model.sv ----
// host model: drives the conversion trigger and the shift clock
`timescale 1ns/100ps
module host_model (
	input  wire logic core_clk_i,
	input  wire logic data_i,
	input  wire logic data_oe_n_i,
	output logic      trigger_o,
	output logic      shift_clk_o
);
	initial
	begin
		trigger_o = 1'b0;
		shift_clk_o = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : cyc

	// a trigger idling low must go high first, or no fall is seen
	task automatic convert(input bit idle_hi, input bit second);
		if (!trigger_o)
		begin
			trigger_o = 1'b1;
			cyc(4);
		end
		trigger_o = 1'b0;
		cyc(40);
		if (second)
		begin
			trigger_o = 1'b1;
			cyc(4);
			trigger_o = 1'b0;
			cyc(40);
		end
		trigger_o = idle_hi;
	endtask : convert

	// shift edges while converting, ending at the idle level of the mode
	task automatic noise(input bit mode);
		repeat (4)
		begin
			shift_clk_o = !mode;
			cyc(4);
			shift_clk_o = mode;
			cyc(4);
		end
	endtask : noise

	// polarity and phase both 0 or both 1; sample just before each rise
	task automatic read_out(input bit mode, output logic [7:0] val,
		output logic [1:0] rel);
		for (int i = 7; i >= 0; i--)
		begin
			if (mode)
			begin
				shift_clk_o = 1'b0;
				cyc(4);
			end
			val[i] = data_i;
			shift_clk_o = 1'b1;
			cyc(i == 0 ? 3 : 4);
			if (i == 0)
			begin
				rel[1] = data_oe_n_i;
				cyc(16);
				rel[0] = data_oe_n_i;
			end
			if (!mode)
			begin
				shift_clk_o = 1'b0;
				cyc(4);
			end
		end
		cyc(4);
	endtask : read_out
endmodule : host_model

// ---- verif/adc_convert_and_serial_readout_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_convert_and_serial_readout_tb;
	logic       core_clk;
	logic       reset_n;
	logic       comparator;
	logic [7:0] vin;
	logic       data_out;
	logic       data_oe_n;
	logic       power_up;
	logic       channel;
	logic       track;
	logic [7:0] dac_code;
	logic       trigger;
	logic       shift_clk;
	wire        dout_pin;
	int         n_errors;
	int         checks;

	assign dout_pin = data_oe_n ? 1'bz : data_out;

	adc_convert_and_serial_readout DUT (
		.core_clk_i           (core_clk),
		.reset_n_i            (reset_n),
		.conversion_trigger_i (trigger),
		.shift_clk_i          (shift_clk),
		.comparator_i         (comparator),
		.data_out_o           (data_out),
		.data_out_oe_n_o      (data_oe_n),
		.analog_power_up_o    (power_up),
		.sample_track_o       (track),
		.channel_select_o     (channel),
		.dac_code_o           (dac_code)
	);

	host_model host (
		.core_clk_i  (core_clk),
		.data_i      (dout_pin),
		.data_oe_n_i (data_oe_n),
		.trigger_o   (trigger),
		.shift_clk_o (shift_clk)
	);

	always #12.5 core_clk = ~core_clk;

	// comparator: 1 when the held input lies below the trial code
	always @(negedge core_clk) comparator <= vin < dac_code;

	function automatic logic [7:0] sar_expect(input logic [7:0] v);
		logic [7:0] code;
		code = 8'h00;
		for (int b = 7; b >= 0; b--)
		begin
			code[b] = 1'b1;
			if (v < code)
				code[b] = 1'b0;
		end
		return code;
	endfunction : sar_expect

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	initial
	begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		give_verdict;
	end

	initial
	begin
		logic [7:0] got;
		logic [1:0] rel;
		bit         mode;
		bit         second;
		bit         skip;
		bit         prev_skip;
		core_clk = 1'b0;
		reset_n = 1'b0;
		vin = 8'h00;
		comparator = 1'b0;
		n_errors = 0;
		checks = 0;
		prev_skip = 1'b0;
		void'($urandom(32'h6bcb29f3));
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (20) @(negedge core_clk);
		check("power with trigger low", {7'h0, power_up}, 8'h00);
		check("enable at reset", {7'h0, data_oe_n}, 8'h01);
		for (int k = 0; k < 14; k++)
		begin
			vin = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : (k == 2) ? 8'h80 : 8'($urandom);
			mode = 1'($urandom);
			second = k > 2 && ($urandom % 3) == 0;
			skip = k > 2 && ($urandom % 4) == 0;
			host.convert(1'($urandom), second);
			check("output in conversion", {7'h0, dout_pin}, 8'h00);
			check("power in conversion", {7'h0, power_up}, 8'h01);
			check("input select", {7'h0, channel}, {7'h0, second | prev_skip});
			check("track in acquisition", {7'h0, track}, 8'h01);
			host.noise(mode);
			repeat (230) @(negedge core_clk);
			check("power after conversion", {7'h0, power_up}, 8'h00);
			check("track after conversion", {7'h0, track}, 8'h00);
			check("msb at completion", {7'h0, dout_pin}, 8'(sar_expect(vin) >> 7));
			repeat ($urandom_range(0, 400)) @(negedge core_clk);
			if (!skip)
			begin
				host.read_out(mode, got, rel);
				check("result", got, sar_expect(vin));
				check("release timing", {6'h0, rel}, 8'h01);
			end
			prev_skip = skip;
		end
		give_verdict;
	end
endmodule : adc_convert_and_serial_readout_tb
